/* fbp_top.sv */
// flash array with per-unit protection, commit and microsecond timing
// assumes one clock, a synchronous power-on reset and an APB master
//
// Overview of operation
// - array split into independently erasable 1-KB units
// - erase sets every bit of unit high
// - program ANDs data into one word
// - two erase units share one policy unit
// - separate 16-bit program and read enables
// - program enable gates program and erase
// - read enable gates data reads, fetch allowed
// - execute-only blocks all data-bus reads
// - refused data read answers with fault
// - refused change raises masked access interrupt
// - software may only clear enable bits
// - uncommitted clears revert at power-on reset
// - commit through control register makes permanent
// - operation timing counts microsecond reload cycles
// - address bit 0 selects committed policy
// - writing one to clear drops interrupt
//
// Chosen here: the register offsets and register access over APB.
`include "fbp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fbp_top
    import fbp_pkg::*;
#(
    parameter int UNITS = 16,
    parameter int AW = 15
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic NV_INIT_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // instruction fetch port
    input wire logic IF_REQ_I,
    input wire logic [AW-1:0] IF_ADDR_I,
    output logic [31:0] IF_RDATA_O,
    output logic IF_VALID_O,
    // data and debugger read port
    input wire logic D_REQ_I,
    input wire logic [AW-1:0] D_ADDR_I,
    output logic [31:0] D_RDATA_O,
    output logic D_VALID_O,
    output logic D_FAULT_O,
    // access interrupt and busy
    output logic ACC_IRQ_O,
    output logic BUSY_O
);
    ////////////////////////////////////////////////////////////////////////
    localparam int WORDS = 1 << (AW - 2);
    localparam int UW = $clog2(UNITS);
    localparam int PROG_CYC = `FBP_PROG_US;
    localparam int ERASE_CYC = `FBP_ERASE_US;
    logic [31:0] mem [WORDS];  // flash array
    logic [UNITS-1:0] nv_pe;  // committed program enables
    logic [UNITS-1:0] nv_re;  // committed read enables
    logic [UNITS-1:0] program_enable_bits;  // live policy
    logic [UNITS-1:0] read_enable_bits;  // live policy
    logic [AW-1:0] flash_address_reg;
    logic [31:0] flash_data_reg;
    logic [7:0] usec_reload;
    logic [1:0] flash_irq_mask_reg;  // bit 0 is access_irq_mask
    logic [1:0] raw_st;  // sticky status
    logic [7:0] usec_cnt;  // cycles within a microsecond
    logic [7:0] us_left;  // microseconds left
    logic [7:0] erase_idx;  // word inside erase unit
    fbp_op_t op;
    fbp_kind_t kind;
    logic wr_acc;  // apb write accepted
    logic refuse;  // refused change this cycle
    logic done_ev;  // operation finished
    logic ctrl_go;  // write or erase requested
    logic d_ok;  // data read allowed

    // protection unit of an address
    function automatic logic [UW-1:0] unit_of(input logic [AW-1:0] a);
        unit_of = a[AW-1 -: UW];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // mapped offsets
    function automatic logic ofs_ok(input logic [7:0] o);
        ofs_ok = (o <= `FBP_OFS_RE) && (o[1:0] == 2'b00);
    endfunction

    // register read data, unimplemented bits read zero
    function automatic logic [31:0] rd_mux(input logic [7:0] o);
        rd_mux = 32'h0;
        if (o == `FBP_OFS_ADDR) begin
            rd_mux[AW-1:0] = flash_address_reg;
        end else if (o == `FBP_OFS_DATA) begin
            rd_mux = flash_data_reg;
        end else if (o == `FBP_OFS_CTRL) begin
            rd_mux[`FBP_CTRL_WRITE] = (op != FBP_IDLE) && (kind == FBP_PROG);
            rd_mux[`FBP_CTRL_ERASE] = (op != FBP_IDLE) && (kind == FBP_ERASE);
        end else if (o == `FBP_OFS_RAW) begin
            rd_mux[1:0] = raw_st;
        end else if (o == `FBP_OFS_MASK) begin
            rd_mux[1:0] = flash_irq_mask_reg;
        end else if (o == `FBP_OFS_CLR) begin
            rd_mux[1:0] = raw_st & flash_irq_mask_reg;
        end else if (o == `FBP_OFS_USEC) begin
            rd_mux[7:0] = usec_reload;
        end else if (o == `FBP_OFS_PE) begin
            rd_mux[UNITS-1:0] = program_enable_bits;
        end else if (o == `FBP_OFS_RE) begin
            rd_mux[UNITS-1:0] = read_enable_bits;
        end
    endfunction

    // apb handshake: answer in the cycle after setup
    assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !ofs_ok(PADDR_I);
            PRDATA_O <= (PSEL_I && !PENABLE_I && !PWRITE_I) ?
                rd_mux(PADDR_I) : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // plain configuration registers
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            flash_address_reg <= '0;
            flash_data_reg <= 32'h0;
            flash_irq_mask_reg <= 2'b00;
            usec_reload <= `FBP_USEC_RST;
        end else if (wr_acc) begin
            if (PADDR_I == `FBP_OFS_ADDR) begin
                flash_address_reg <= PWDATA_I[AW-1:0];
            end else if (PADDR_I == `FBP_OFS_DATA) begin
                flash_data_reg <= PWDATA_I;
            end else if (PADDR_I == `FBP_OFS_MASK) begin
                flash_irq_mask_reg <= PWDATA_I[1:0];
            end else if (PADDR_I == `FBP_OFS_USEC) begin
                usec_reload <= PWDATA_I[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // committed copies: kept across power-on reset, set by factory init
    always_ff @(posedge MCLK_I) begin
        if (NV_INIT_I) begin
            nv_pe <= '1;
            nv_re <= '1;
        end else if (wr_acc && PADDR_I == `FBP_OFS_CTRL &&
                     PWDATA_I[`FBP_CTRL_COMMIT]) begin
            if (flash_address_reg[`FBP_SEL_PE]) begin
                nv_pe <= program_enable_bits;
            end else begin
                nv_re <= read_enable_bits;
            end
        end
    end

    // live policy: reloads committed copy at power-on reset
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I || NV_INIT_I) begin
            program_enable_bits <= NV_INIT_I ? '1 : nv_pe;
            read_enable_bits <= NV_INIT_I ? '1 : nv_re;
        end else if (wr_acc && PADDR_I == `FBP_OFS_PE) begin
            program_enable_bits <= program_enable_bits &
                PWDATA_I[UNITS-1:0];
        end else if (wr_acc && PADDR_I == `FBP_OFS_RE) begin
            read_enable_bits <= read_enable_bits &
                PWDATA_I[UNITS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operation sequencer
    assign ctrl_go = wr_acc && PADDR_I == `FBP_OFS_CTRL && op == FBP_IDLE &&
        (PWDATA_I[`FBP_CTRL_WRITE] || PWDATA_I[`FBP_CTRL_ERASE]);
    assign refuse = ctrl_go &&
        !program_enable_bits[unit_of(flash_address_reg)];
    assign done_ev = (op == FBP_APPLY) &&
        (kind == FBP_PROG || erase_idx == 8'hff);
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            op <= FBP_IDLE;
            kind <= FBP_PROG;
            usec_cnt <= 8'h0;
            us_left <= 8'h0;
            erase_idx <= 8'h0;
        end else begin
            case (op)
                FBP_IDLE: begin
                    usec_cnt <= usec_reload;
                    erase_idx <= 8'h0;
                    // refused changes never start
                    if (ctrl_go && !refuse) begin
                        op <= FBP_WAIT;
                        kind <= PWDATA_I[`FBP_CTRL_WRITE] ? FBP_PROG :
                            FBP_ERASE;
                        us_left <= PWDATA_I[`FBP_CTRL_WRITE] ?
                            8'(PROG_CYC) : 8'(ERASE_CYC);
                    end
                end
                FBP_WAIT: begin
                    // usec_reload + 1 cycles per microsecond
                    if (usec_cnt == 8'h0) begin
                        usec_cnt <= usec_reload;
                        us_left <= us_left - 8'h1;
                        if (us_left == 8'h1) begin
                            op <= FBP_APPLY;
                        end
                    end else begin
                        usec_cnt <= usec_cnt - 8'h1;
                    end
                end
                FBP_APPLY: begin
                    erase_idx <= erase_idx + 8'h1;
                    if (done_ev) begin
                        op <= FBP_IDLE;
                    end
                end
                default: begin
                    op <= FBP_IDLE;
                end
            endcase
        end
    end

    // array writes: word program ands, erase walks the 1-KB unit
    always_ff @(posedge MCLK_I) begin
        if (op == FBP_APPLY && kind == FBP_PROG) begin
            mem[flash_address_reg[AW-1:2]] <=
                mem[flash_address_reg[AW-1:2]] & flash_data_reg;
        end else if (op == FBP_APPLY) begin
            mem[{flash_address_reg[AW-1:10], erase_idx}] <=
                32'hffff_ffff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, set wins over clear
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            raw_st <= 2'b00;
            ACC_IRQ_O <= 1'b0;
            BUSY_O <= 1'b0;
        end else begin
            raw_st[`FBP_ST_ACCESS] <= refuse || (raw_st[`FBP_ST_ACCESS] &&
                !(wr_acc && PADDR_I == `FBP_OFS_CLR &&
                  PWDATA_I[`FBP_ST_ACCESS]));
            raw_st[`FBP_ST_DONE] <= done_ev || (raw_st[`FBP_ST_DONE] &&
                !(wr_acc && PADDR_I == `FBP_OFS_CLR &&
                  PWDATA_I[`FBP_ST_DONE]));
            ACC_IRQ_O <= raw_st[`FBP_ST_ACCESS] &&
                flash_irq_mask_reg[`FBP_ST_ACCESS];
            BUSY_O <= (op != FBP_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read ports, held off while an operation runs
    assign d_ok = read_enable_bits[unit_of(D_ADDR_I)];
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            IF_VALID_O <= 1'b0;
            IF_RDATA_O <= 32'h0;
            D_VALID_O <= 1'b0;
            D_RDATA_O <= 32'h0;
            D_FAULT_O <= 1'b0;
        end else begin
            IF_VALID_O <= IF_REQ_I && op == FBP_IDLE && !IF_VALID_O;
            IF_RDATA_O <= mem[IF_ADDR_I[AW-1:2]];
            D_VALID_O <= D_REQ_I && op == FBP_IDLE && !D_VALID_O;
            D_RDATA_O <= d_ok ? mem[D_ADDR_I[AW-1:2]] : 32'h0;
            D_FAULT_O <= D_REQ_I && op == FBP_IDLE && !D_VALID_O &&
                !d_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence refused_s;
        ctrl_go && refuse;
    endsequence
    sequence irq_up_s;
        ##2 ACC_IRQ_O;
    endsequence

    refuse_irq_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        refused_s ##0 flash_irq_mask_reg[0] |-> irq_up_s)
        else $error("masked access interrupt missing");
    refuse_idle_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        refused_s |=> op == FBP_IDLE)
        else $error("refused change started");
    pe_clear_a: assert property (@(posedge MCLK_I) disable iff
        (SYS_RST_I || NV_INIT_I)
        !$past(SYS_RST_I) && !$past(NV_INIT_I) |->
        (program_enable_bits & ~$past(program_enable_bits)) == '0)
        else $error("enable bit went high");
    re_only_a: assert property (@(posedge MCLK_I) disable iff
        (SYS_RST_I || NV_INIT_I)
        !$past(SYS_RST_I) && !$past(NV_INIT_I) |->
        (read_enable_bits & ~$past(read_enable_bits)) == '0)
        else $error("read enable bit set by software");
    fault_read_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        D_REQ_I && op == FBP_IDLE && !D_VALID_O && !d_ok |=>
        D_FAULT_O && D_RDATA_O == 32'h0)
        else $error("protected data read not faulted");
    fetch_ok_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        IF_REQ_I && op == FBP_IDLE && !IF_VALID_O |=> IF_VALID_O)
        else $error("fetch not answered");
    usec_rst_a: assert property (@(posedge MCLK_I)
        SYS_RST_I |=> usec_reload == `FBP_USEC_RST)
        else $error("reload value wrong after reset");
    clr_irq_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        wr_acc && PADDR_I == `FBP_OFS_CLR && PWDATA_I[0] && !refuse |=>
        !raw_st[0] ##1 !ACC_IRQ_O)
        else $error("access status not cleared");
    commit_a: assert property (@(posedge MCLK_I) disable iff (NV_INIT_I)
        wr_acc && PADDR_I == `FBP_OFS_CTRL && PWDATA_I[3] &&
        flash_address_reg[0] |=> nv_pe == $past(program_enable_bits))
        else $error("commit did not store policy");
endmodule
`default_nettype wire

/* fbp_defs.svh */
// constants of the flash protection and timing block
// assumes inclusion by bare name from the top module
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH
// register byte offsets
`define FBP_OFS_ADDR 8'h00
`define FBP_OFS_DATA 8'h04
`define FBP_OFS_CTRL 8'h08
`define FBP_OFS_RAW 8'h0c
`define FBP_OFS_MASK 8'h10
`define FBP_OFS_CLR 8'h14
`define FBP_OFS_USEC 8'h18
`define FBP_OFS_PE 8'h1c
`define FBP_OFS_RE 8'h20
// control register bit positions
`define FBP_CTRL_WRITE 0
`define FBP_CTRL_ERASE 1
`define FBP_CTRL_COMMIT 3
// status and mask bit positions
`define FBP_ST_ACCESS 0
`define FBP_ST_DONE 1
// address register bit choosing the committed policy
`define FBP_SEL_PE 0
// reset value and clock frequency
`define FBP_USEC_RST 8'h7c
`define FBP_CLK_MHZ 125
// operation times in microseconds
`define FBP_PROG_US 20
`define FBP_ERASE_US 20
`endif

/* fbp_pkg.sv */
// types shared by the flash protection and timing block
// assumes fbp_defs.svh is on the include path
package fbp_pkg;
    // flash operation sequencer states
    typedef enum logic [1:0] {
        FBP_IDLE,
        FBP_WAIT,
        FBP_APPLY
    } fbp_op_t;
    // kind of pending flash change
    typedef enum logic {
        FBP_PROG,
        FBP_ERASE
    } fbp_kind_t;
endpackage

/* fbp_bus_model.sv */
// model of the core buses: fetch path and data/debugger read path
// assumes the read-port contract of the flash protection block
`timescale 1ns/1ps
`default_nettype none
module fbp_bus_model (
    // clock
    input wire logic clk_i,
    // fetch path
    output var logic if_req_o,
    output var logic [14:0] if_addr_o,
    input wire logic if_valid_i,
    input wire logic [31:0] if_rdata_i,
    // data path
    output var logic d_req_o,
    output var logic [14:0] d_addr_o,
    input wire logic d_valid_i,
    input wire logic [31:0] d_rdata_i,
    input wire logic d_fault_i
);
    ////////////////////////////////////////////////////////////////////////
    // idle levels at time zero
    initial begin
        if_req_o = 1'b0;
        d_req_o = 1'b0;
        if_addr_o = '0;
        d_addr_o = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one read; request held until valid or for at most 50 cycles, address scrambled after release
    task automatic read_word(input logic fetch, input logic [14:0] a,
                             output logic [31:0] d, output logic f);
        int i;
        d = '0;
        f = 1'b1;
        @(posedge clk_i);
        if (fetch) begin
            if_req_o <= 1'b1;
            if_addr_o <= a;
        end else begin
            d_req_o <= 1'b1;
            d_addr_o <= a;
        end
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (fetch ? (if_valid_i === 1'b1) : (d_valid_i === 1'b1)) begin
                d = fetch ? if_rdata_i : d_rdata_i;
                f = fetch ? 1'b0 : d_fault_i;
                break;
            end
        end
        // released lines show no stale address
        if_req_o <= 1'b0;
        d_req_o <= 1'b0;
        if (fetch) if_addr_o <= ~a;
        else d_addr_o <= ~a;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench of the flash protection and timing block
// assumes fbp_top and fbp_bus_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // design stimulus and response
    logic MCLK_I = 0, SYS_RST_I = 1, NV_INIT_I = 1;
    logic psel = 0, pen = 0, pwr = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, if_rdata, d_rdata;
    logic pready, pslverr, if_req, if_valid, d_req, d_valid, d_fault;
    logic irq, busy;
    logic [14:0] if_addr, d_addr;
    int fail_count = 0, compares = 0;
    ////////////////////////////////////////////////////////////////////////
    fbp_top fbp_top_i (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
        .NV_INIT_I(NV_INIT_I), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .IF_REQ_I(if_req), .IF_ADDR_I(if_addr), .IF_RDATA_O(if_rdata),
        .IF_VALID_O(if_valid), .D_REQ_I(d_req), .D_ADDR_I(d_addr),
        .D_RDATA_O(d_rdata), .D_VALID_O(d_valid), .D_FAULT_O(d_fault),
        .ACC_IRQ_O(irq), .BUSY_O(busy));
    fbp_bus_model fbp_bus_model_i (.clk_i(MCLK_I), .if_req_o(if_req),
        .if_addr_o(if_addr), .if_valid_i(if_valid), .if_rdata_i(if_rdata),
        .d_req_o(d_req), .d_addr_o(d_addr), .d_valid_i(d_valid),
        .d_rdata_i(d_rdata), .d_fault_i(d_fault));
    ////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial forever #4 MCLK_I = ~MCLK_I;
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // apb transfer: setup, access held until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic e);
        @(posedge MCLK_I);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge MCLK_I);
        pen <= 1'b1;
        // wait for pready; only the watchdog ends a lost answer
        do begin
            @(posedge MCLK_I);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic e;
        apb(1'b0, a, '0, v, e);
    endtask
    // start a flash change and count the cycles it keeps busy high
    task automatic op(input logic [31:0] c, output int n);
        int i;
        n = 0;
        wr(8'h08, c);
        for (i = 0; i < 4 && busy !== 1'b1; i++) @(posedge MCLK_I);
        while (busy === 1'b1 && n < 4000) begin
            @(posedge MCLK_I);
            n++;
        end
    endtask
    task automatic rp(input logic fe, input logic [14:0] a,
                      input logic [31:0] x, input logic xf);
        logic [31:0] d;
        logic f;
        fbp_bus_model_i.read_word(fe, a, d, f);
        check(d, x);
        check({31'h0, f}, {31'h0, xf});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge MCLK_I);
        fail_count++;
        wrap_up;
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] v;
        logic e;
        int n;
        repeat (4) @(posedge MCLK_I);
        SYS_RST_I <= 1'b0;
        NV_INIT_I <= 1'b0;
        rd(8'h18, v); check(v, 32'h7c);
        rd(8'h1c, v); check(v, 32'hffff);
        rd(8'h20, v); check(v, 32'hffff);
        apb(1'b0, 8'h24, '0, v, e); check({v[30:0], e}, 32'h1);
        wr(8'h00, 32'h0); op(32'h2, n); check(n, 2756);
        wr(8'h18, 32'h1);
        wr(8'h00, 32'h400); op(32'h2, n); check(n, 296);
        rp(1'b1, 15'h0, 32'hffffffff, 1'b0);
        rp(1'b0, 15'h7fc, 32'hffffffff, 1'b0);
        wr(8'h00, 32'h0); wr(8'h04, 32'h12345678);
        op(32'h1, n); check(n, 41);
        wr(8'h04, 32'hffff0000); op(32'h1, n);
        rp(1'b1, 15'h0, 32'h12340000, 1'b0);
        rp(1'b0, 15'h4, 32'hffffffff, 1'b0);
        wr(8'h00, 32'h400); wr(8'h04, 32'h0); op(32'h1, n);
        op(32'h2, n);
        rp(1'b0, 15'h400, 32'hffffffff, 1'b0);
        rp(1'b0, 15'h0, 32'h12340000, 1'b0);
        rd(8'h0c, v); check(v & 32'h2, 32'h2);
        wr(8'h14, 32'h3);
        // clear program enable of unit 0; a set attempt is ignored
        wr(8'h1c, 32'hfffe); wr(8'h1c, 32'hffff);
        rd(8'h1c, v); check(v, 32'hfffe);
        wr(8'h00, 32'h404); op(32'h1, n); check(n, 0);
        rp(1'b0, 15'h404, 32'hffffffff, 1'b0);
        rd(8'h0c, v); check(v & 32'h1, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(8'h10, 32'h1); repeat (2) @(posedge MCLK_I);
        check({31'h0, irq}, 32'h1);
        wr(8'h14, 32'h1); repeat (2) @(posedge MCLK_I);
        check({31'h0, irq}, 32'h0);
        rd(8'h0c, v); check(v & 32'h1, 32'h0);
        wr(8'h00, 32'h0); op(32'h2, n); check(n, 0);
        rp(1'b0, 15'h0, 32'h12340000, 1'b0);
        wr(8'h00, 32'h800); op(32'h2, n); check(n, 296);
        // unit 1 becomes execute-only for data reads
        wr(8'h20, 32'hfffd);
        rp(1'b0, 15'h800, 32'h0, 1'b1);
        rp(1'b1, 15'h800, 32'hffffffff, 1'b0);
        rp(1'b0, 15'h0, 32'h12340000, 1'b0);
        // commit program enables only, then power-on reset
        wr(8'h00, 32'h1); wr(8'h08, 32'h8);
        @(posedge MCLK_I);
        SYS_RST_I <= 1'b1;
        repeat (2) @(posedge MCLK_I);
        SYS_RST_I <= 1'b0;
        rd(8'h1c, v); check(v, 32'hfffe);
        rd(8'h20, v); check(v, 32'hffff);
        rp(1'b0, 15'h800, 32'hffffffff, 1'b0);
        wrap_up;
    end
endmodule
`default_nettype wire
